// >>> core/irq_enable_priority.sv
// Purpose: interrupt enable and four-level priority registers with nested
//          request arbitration toward the cpu core, on a wishbone slave
// Assumes: source request flags come from logic on mclk; cpu accepts the
//          registered offer with a take pulse and closes a handler with ret
// Notes:   registers sit at byte address four times their index
`include "irq_prio_defines.svh"

module irq_enable_priority (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [9:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // interrupt sources
  input  wire logic [6:0]               basic_req,
  input  wire logic [7:0]               t2_req,
  // cpu core
  output irq_prio_pkg::irq_offer_t      cpu_offer,
  input  wire logic                     cpu_take,
  input  wire logic                     cpu_ret,
  // block interrupt
  output logic                          irq
);
  import irq_prio_pkg::*;

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0]            basic_irq_enable_reg;
  logic [7:0]            basic_irq_enable_next;
  logic [7:0]            basic_priority_high_reg;
  logic [7:0]            basic_priority_high_next;
  logic [7:0]            basic_priority_low_reg;
  logic [7:0]            basic_priority_low_next;
  logic [7:0]            timer2_irq_enable_reg;
  logic [7:0]            timer2_irq_enable_next;
  logic [7:0]            timer2_priority_low_reg;
  logic [7:0]            timer2_priority_low_next;
  logic [7:0]            timer2_priority_high_reg;
  logic [7:0]            timer2_priority_high_next;
  logic [`EVT_WIDTH-1:0] evt_status_reg;
  logic [`EVT_WIDTH-1:0] evt_status_next;
  logic [`EVT_WIDTH-1:0] evt_mask_reg;
  logic [`EVT_WIDTH-1:0] evt_mask_next;

  // bus state
  logic                  ack_reg;
  logic                  ack_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  irq_offer_t            offer_reg;
  irq_offer_t            offer_next;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [7:0]            idx;
  logic                  bus_req;
  logic                  wr_en;
  logic                  rd_en;

  assign idx     = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_en   = bus_req && !wb_we_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_idx);
    hit = (a == reg_idx);
  endfunction

  // ------------------------------------------------------------------
  // per-register strobes
  // ------------------------------------------------------------------
  logic                  wr_basic_en;
  logic                  wr_basic_hi;
  logic                  wr_basic_lo;
  logic                  wr_t2_en;
  logic                  wr_t2_lo;
  logic                  wr_t2_hi;
  logic                  wr_evt_mask;
  logic                  rd_evt_status;

  assign wr_basic_en   = wr_en && hit(idx, `IDX_BASIC_IRQ_EN);
  assign wr_basic_hi   = wr_en && hit(idx, `IDX_BASIC_PRIO_HI);
  assign wr_basic_lo   = wr_en && hit(idx, `IDX_BASIC_PRIO_LO);
  assign wr_t2_en      = wr_en && hit(idx, `IDX_T2_IRQ_EN);
  assign wr_t2_lo      = wr_en && hit(idx, `IDX_T2_PRIO_LO);
  assign wr_t2_hi      = wr_en && hit(idx, `IDX_T2_PRIO_HI);
  assign wr_evt_mask   = wr_en && hit(idx, `IDX_EVT_MASK);
  assign rd_evt_status = rd_en && hit(idx, `IDX_EVT_STATUS);

  // ------------------------------------------------------------------
  // source configuration
  // ------------------------------------------------------------------
  src_cfg_t              cfg;
  src_vec_t              pending;
  irq_offer_t            arb_offer;
  svc_vec_t              in_service;
  logic                  busy;
  level_t                active_level;
  logic                  underflow;
  logic                  take;

  // timer-2 enable fields, overflow down to capture 0
  logic                  t2_overflow_irq_en;
  logic                  compare2_irq_en;
  logic                  compare1_irq_en;
  logic                  compare0_irq_en;
  logic                  capture3_irq_en;
  logic                  capture2_irq_en;
  logic                  capture1_irq_en;
  logic                  capture0_irq_en;
  logic                  global_irq_en;

  assign {t2_overflow_irq_en, compare2_irq_en, compare1_irq_en, compare0_irq_en,
          capture3_irq_en, capture2_irq_en, capture1_irq_en,
          capture0_irq_en} = timer2_irq_enable_reg;
  assign global_irq_en = basic_irq_enable_reg[`GLOBAL_EN_BIT];

  always_comb begin
    // basic sources 0..6, timer-2 sources 7..14 in register bit order
    cfg.enable    = {t2_overflow_irq_en, compare2_irq_en, compare1_irq_en,
                     compare0_irq_en, capture3_irq_en, capture2_irq_en,
                     capture1_irq_en, capture0_irq_en,
                     basic_irq_enable_reg[`BASIC_SRC_COUNT-1:0]};
    cfg.prio_lo   = {timer2_priority_low_reg,
                     basic_priority_low_reg[`BASIC_SRC_COUNT-1:0]};
    cfg.prio_hi   = {timer2_priority_high_reg,
                     basic_priority_high_reg[`BASIC_SRC_COUNT-1:0]};
    cfg.global_en = global_irq_en;
    pending       = {t2_req, basic_req};
  end

  irq_source_arbiter u_arbiter (
    .cfg          (cfg),
    .pending      (pending),
    .busy         (busy),
    .active_level (active_level),
    .offer        (arb_offer)
  );

  // a take is only honoured while the registered offer is still valid
  assign take = cpu_take && offer_reg.valid;

  irq_service_tracker u_tracker (
    .mclk         (mclk),
    .srst         (srst),
    .take         (take),
    .take_level   (offer_reg.level),
    .ret          (cpu_ret),
    .in_service   (in_service),
    .busy         (busy),
    .active_level (active_level),
    .underflow    (underflow)
  );

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_comb begin
    basic_irq_enable_next     = basic_irq_enable_reg;
    basic_priority_high_next  = basic_priority_high_reg;
    basic_priority_low_next   = basic_priority_low_reg;
    timer2_irq_enable_next    = timer2_irq_enable_reg;
    timer2_priority_low_next  = timer2_priority_low_reg;
    timer2_priority_high_next = timer2_priority_high_reg;
    evt_mask_next             = evt_mask_reg;
    if (wr_basic_en) begin
      basic_irq_enable_next = wb_dat_i[7:0];
    end
    if (wr_basic_hi) begin
      basic_priority_high_next = {1'b0, wb_dat_i[6:0]};
    end
    if (wr_basic_lo) begin
      basic_priority_low_next = {1'b0, wb_dat_i[6:0]};
    end
    if (wr_t2_en) begin
      timer2_irq_enable_next = wb_dat_i[7:0];
    end
    if (wr_t2_lo) begin
      timer2_priority_low_next = wb_dat_i[7:0];
    end
    if (wr_t2_hi) begin
      timer2_priority_high_next = wb_dat_i[7:0];
    end
    if (wr_evt_mask) begin
      evt_mask_next = wb_dat_i[`EVT_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // event status, read clears, a new event wins over the clear
  // ------------------------------------------------------------------
  logic [`EVT_WIDTH-1:0] evt_set;

  always_comb begin
    evt_set                 = '0;
    evt_set[`EVT_ACCEPT]    = take;
    evt_set[`EVT_PREEMPT]   = take && busy;
    evt_set[`EVT_UNDERFLOW] = underflow;
    evt_status_next         = evt_status_reg;
    if (rd_evt_status) begin
      evt_status_next = '0;
    end
    evt_status_next = evt_status_next | evt_set;
  end

  // ------------------------------------------------------------------
  // read data, ack and offer
  // ------------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    ack_next   = bus_req;
    if (bus_req) begin
      rdata_next = '0;
    end
    if (rd_en) begin
      unique case (idx)
        `IDX_BASIC_IRQ_EN:  rdata_next = {24'h000000, basic_irq_enable_reg};
        `IDX_BASIC_PRIO_HI: rdata_next = {24'h000000, basic_priority_high_reg};
        `IDX_BASIC_PRIO_LO: rdata_next = {24'h000000, basic_priority_low_reg};
        `IDX_T2_IRQ_EN:     rdata_next = {24'h000000, timer2_irq_enable_reg};
        `IDX_T2_PRIO_LO:    rdata_next = {24'h000000, timer2_priority_low_reg};
        `IDX_T2_PRIO_HI:    rdata_next = {24'h000000, timer2_priority_high_reg};
        `IDX_EVT_STATUS:    rdata_next = {29'h00000000, evt_status_reg};
        `IDX_EVT_MASK:      rdata_next = {29'h00000000, evt_mask_reg};
        `IDX_SERVICE:       rdata_next = {25'h0000000, offer_reg.valid,
                                          offer_reg.level, in_service};
        default:            rdata_next = '0;
      endcase
    end
    // drop the offer at a take so the same request is not taken twice
    offer_next = take ? '0 : arb_offer;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // configuration group
  always_ff @(posedge mclk) begin
    if (srst) begin
      basic_irq_enable_reg     <= `REG_RESET;
      basic_priority_high_reg  <= `REG_RESET;
      basic_priority_low_reg   <= `REG_RESET;
      timer2_irq_enable_reg    <= `REG_RESET;
      timer2_priority_low_reg  <= `REG_RESET;
      timer2_priority_high_reg <= `REG_RESET;
    end else begin
      basic_irq_enable_reg     <= basic_irq_enable_next;
      basic_priority_high_reg  <= basic_priority_high_next;
      basic_priority_low_reg   <= basic_priority_low_next;
      timer2_irq_enable_reg    <= timer2_irq_enable_next;
      timer2_priority_low_reg  <= timer2_priority_low_next;
      timer2_priority_high_reg <= timer2_priority_high_next;
    end
  end

  // event group
  always_ff @(posedge mclk) begin
    if (srst) begin
      evt_status_reg           <= '0;
      evt_mask_reg             <= '0;
    end else begin
      evt_status_reg           <= evt_status_next;
      evt_mask_reg             <= evt_mask_next;
    end
  end

  // bus and offer group
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_reg                  <= 1'b0;
      rdata_reg                <= '0;
      offer_reg                <= '0;
    end else begin
      ack_reg                  <= ack_next;
      rdata_reg                <= rdata_next;
      offer_reg                <= offer_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdata_reg;
  assign cpu_offer = offer_reg;
  assign irq       = |(evt_status_reg & evt_mask_reg);

endmodule

// >>> core/irq_prio_defines.svh
// Purpose: register indices, field positions, reset values of the interrupt
//          enable and priority block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// ------------------------------------------------------------------
// register indices
// ------------------------------------------------------------------
`define IDX_BASIC_PRIO_HI  8'hb7
`define IDX_BASIC_PRIO_LO  8'hb8
`define IDX_T2_IRQ_EN      8'he8
`define IDX_T2_PRIO_LO     8'hf8
`define IDX_T2_PRIO_HI     8'hf9
`define IDX_BASIC_IRQ_EN   8'ha8
`define IDX_EVT_STATUS     8'hc0
`define IDX_EVT_MASK       8'hc1
`define IDX_SERVICE        8'hc2

// ------------------------------------------------------------------
// sizes and fields
// ------------------------------------------------------------------
`define BASIC_SRC_COUNT    7
`define T2_SRC_COUNT       8
`define SRC_COUNT          15
`define SRC_ID_W           4
`define LEVEL_COUNT        4
`define GLOBAL_EN_BIT      7
`define T2_OVF_BIT         7
`define COMPARE2_BIT       6
`define BASIC_UNUSED_BIT   7
`define REG_RESET          8'h00
`define EVT_WIDTH          3
`define EVT_ACCEPT         0
`define EVT_PREEMPT        1
`define EVT_UNDERFLOW      2
`define SVC_OFFER_BIT      6

`endif

// >>> core/irq_prio_pkg.sv
// Purpose: shared types of the interrupt enable and priority block
// Assumes: irq_prio_defines.svh holds all numbers
// Notes:   none
`include "irq_prio_defines.svh"

package irq_prio_pkg;

  typedef logic [1:0]                 level_t;
  typedef logic [`SRC_ID_W-1:0]       src_id_t;
  typedef logic [`SRC_COUNT-1:0]      src_vec_t;
  typedef logic [`LEVEL_COUNT-1:0]    svc_vec_t;

  // offer of one interrupt to the cpu core
  typedef struct packed {
    logic    valid;
    src_id_t source;
    level_t  level;
  } irq_offer_t;

  // per-source configuration, flattened 0..6 basic, 7..14 timer-2
  typedef struct packed {
    src_vec_t enable;
    src_vec_t prio_hi;
    src_vec_t prio_lo;
    logic     global_en;
  } src_cfg_t;

endpackage

// >>> core/irq_source_arbiter.sv
// Purpose: pick the highest-level eligible source and decide preemption
// Assumes: purely combinational, same clock as its user
// Notes:   ties within a level go to the lowest source number
`include "irq_prio_defines.svh"

module irq_source_arbiter (
  // configuration and requests
  input  wire irq_prio_pkg::src_cfg_t   cfg,
  input  wire irq_prio_pkg::src_vec_t   pending,
  // service state
  input  wire logic                     busy,
  input  wire irq_prio_pkg::level_t     active_level,
  // result
  output irq_prio_pkg::irq_offer_t      offer
);
  import irq_prio_pkg::*;

  function automatic level_t level_of(input logic hi, input logic lo);
    level_of = {hi, lo};
  endfunction

  src_vec_t eligible;
  level_t   best_level;
  src_id_t  best_src;
  logic     any;

  always_comb begin
    eligible   = pending & cfg.enable & {`SRC_COUNT{cfg.global_en}};
    best_level = 2'b00;
    best_src   = '0;
    any        = 1'b0;
    for (int i = `SRC_COUNT - 1; i >= 0; i--) begin
      if (eligible[i] && (!any || level_of(cfg.prio_hi[i], cfg.prio_lo[i]) >= best_level)) begin
        any        = 1'b1;
        best_level = level_of(cfg.prio_hi[i], cfg.prio_lo[i]);
        best_src   = src_id_t'(i);
      end
    end
    offer.valid  = any && (!busy || best_level > active_level);
    offer.source = best_src;
    offer.level  = best_level;
  end

endmodule

// >>> core/irq_service_tracker.sv
// Purpose: remember which levels are in service, nested
// Assumes: a take only carries a level above every level in service
// Notes:   a return closes the highest level in service
`include "irq_prio_defines.svh"

module irq_service_tracker (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // cpu events
  input  wire logic                   take,
  input  wire irq_prio_pkg::level_t   take_level,
  input  wire logic                   ret,
  // state
  output irq_prio_pkg::svc_vec_t      in_service,
  output logic                        busy,
  output irq_prio_pkg::level_t        active_level,
  output logic                        underflow
);
  import irq_prio_pkg::*;

  svc_vec_t svc_reg;
  svc_vec_t svc_next;

  always_comb begin
    svc_next     = svc_reg;
    active_level = 2'b00;
    for (int l = 0; l < `LEVEL_COUNT; l++) begin
      if (svc_reg[l]) begin
        active_level = level_t'(l);
      end
    end
    // preempted levels stay set and resume when the newer one returns
    if (ret && svc_reg != '0) begin
      svc_next[active_level] = 1'b0;
    end
    if (take) begin
      svc_next[take_level] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      svc_reg <= '0;
    end else begin
      svc_reg <= svc_next;
    end
  end

  assign in_service = svc_reg;
  assign busy       = (svc_reg != '0);
  assign underflow  = ret && (svc_reg == '0);

endmodule

// >>> testbench/irq_enable_priority_properties.sv
// Purpose: port properties of the enable and priority block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the top module at the foot
module irq_enable_priority_properties import irq_prio_pkg::*; (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     srst,
  // wishbone
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [9:0]               wb_adr_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  // sources and cpu
  input wire logic [6:0]               basic_req,
  input wire logic [7:0]               t2_req,
  input wire irq_prio_pkg::irq_offer_t cpu_offer,
  input wire logic                     cpu_take,
  input wire logic                     cpu_ret,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // properties
  // ----------------
  logic [14:0] req_reg;
  logic [14:0] req_next;
  always_comb req_next = {t2_req, basic_req};
  always_ff @(posedge mclk) req_reg <= req_next;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h00 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_unused_bit;
    wb_ack_o && !wb_we_i && (wb_adr_i[9:2] == 8'hb7 || wb_adr_i[9:2] == 8'hb8)
      |-> !wb_dat_o[7];
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("unused bit set");
  property p_reset_quiet; $past(srst) |-> !wb_ack_o && !cpu_offer.valid && !irq; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_offer_req; cpu_offer.valid |-> req_reg[cpu_offer.source]; endproperty
  a_offer_req: assert property (p_offer_req) else $error("offer without request");
  property p_no_req; req_reg == 15'h0 |-> !cpu_offer.valid; endproperty
  a_no_req: assert property (p_no_req) else $error("offer while idle");
  property p_take_clears; cpu_take && cpu_offer.valid |=> !cpu_offer.valid; endproperty
  a_take_clears: assert property (p_take_clears) else $error("offer after take");
  property p_top_blocks;
    cpu_take && cpu_offer.valid && cpu_offer.level == 2'h3 ##1 !cpu_ret [*2] |-> !cpu_offer.valid;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("offer above top level");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_top_take: cover property (cpu_take && cpu_offer.valid && cpu_offer.level == 2'h3);
  c_irq: cover property (irq);
endmodule

bind irq_enable_priority irq_enable_priority_properties u_props (
  .mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .basic_req(basic_req),
  .t2_req(t2_req), .cpu_offer(cpu_offer), .cpu_take(cpu_take), .cpu_ret(cpu_ret), .irq(irq));

// >>> testbench/cpu_core_model.sv
// Purpose: cpu core that takes offers and closes handlers
// Assumes: handler runs hold cycles, resumed handler runs hold again
// Notes:   kick_ret forces a close even with nothing in service
module cpu_core_model import irq_prio_pkg::*; (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     srst,
  // link to the block
  input wire irq_prio_pkg::irq_offer_t offer,
  output logic                         take,
  output logic                         ret,
  // behaviour
  input wire logic                     auto_en,
  input wire logic                     kick_ret,
  input wire logic [7:0]               hold
);
  timeunit 1ns;
  timeprecision 1ns;
  int depth;
  int timer;
  // ----------------
  // nested service
  // ----------------
  always @(posedge mclk) begin
    if (srst) begin
      take <= 1'b0;
      ret <= 1'b0;
      depth = 0;
      timer = 0;
    end else begin
      if (take && offer.valid) begin
        depth = depth + 1;
        timer = hold;
      end
      if (ret && depth > 0) depth = depth - 1;
      take <= 1'b0;
      ret <= 1'b0;
      if (kick_ret) ret <= 1'b1;
      else if (depth > 0 && timer == 0 && !take && !ret) begin
        ret <= 1'b1;
        timer = hold;
      end else if (auto_en && offer.valid && !take && !ret) take <= 1'b1;
      if (timer > 0) timer = timer - 1;
    end
  end
endmodule

// >>> testbench/interrupt_enable_priority_regs_tb.sv
// Purpose: self-checking bench of the enable and priority block
// Assumes: one clock of 50 ns, reset held 20 cycles
// Notes:   random levels and data from a fixed seed
module interrupt_enable_priority_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, srst, cyc, stb, we, ack, irq, take, ret, auto_en, kick;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [14:0] req;
  logic [7:0]  hold, d;
  logic [1:0]  lv;
  logic [7:0]  taken[$];
  logic [7:0]  idxs[9] = '{8'hb7, 8'hb8, 8'he8, 8'hf8, 8'hf9, 8'ha8, 8'hc1, 8'hc0, 8'h00};
  int          failures, checked, rets, n;
  irq_prio_pkg::irq_offer_t offer;

  irq_enable_priority dut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .basic_req(req[6:0]), .t2_req(req[14:7]), .cpu_offer(offer),
    .cpu_take(take), .cpu_ret(ret), .irq(irq));
  cpu_core_model cpu (.mclk(mclk), .srst(srst), .offer(offer), .take(take), .ret(ret),
    .auto_en(auto_en), .kick_ret(kick), .hold(hold));

  // ----------------
  // helpers
  // ----------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [7:0] rmask(input logic [7:0] idx);
    return (idx == 8'hb7 || idx == 8'hb8) ? 8'h7f : (idx == 8'hc1) ? 8'h07 : 8'hff;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] dv);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, dv};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k == 20) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // one source with level l, its enable and the global enable
  task automatic cfg(input int s, input logic [1:0] l, input logic en, input logic g);
    logic [7:0] b;
    logic bs;
    bs = (s < 7);
    b = bs ? 8'h01 << s : 8'h01 << (s - 7);
    bus(1'b1, 8'hb7, bs && l[1] ? b : 8'h00);
    bus(1'b1, 8'hb8, bs && l[0] ? b : 8'h00);
    bus(1'b1, 8'hf9, !bs && l[1] ? b : 8'h00);
    bus(1'b1, 8'hf8, !bs && l[0] ? b : 8'h00);
    bus(1'b1, 8'he8, !bs && en ? b : 8'h00);
    bus(1'b1, 8'ha8, {g, 7'h00} | (bs && en ? b : 8'h00));
  endtask
  task results;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // handler software clears the flag it serves
  always @(posedge mclk) begin
    if (ret) rets++;
    if (take && offer.valid) begin
      taken.push_back({offer.source, 4'(rets)});
      req[offer.source] <= 1'b0;
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end

  // ----------------
  // tests
  // ----------------
  initial begin
    {cyc, stb, we, auto_en, kick} = 5'h0;
    adr = 10'h0;
    sel = 4'hf;
    wdat = 32'h0;
    req = 15'h0;
    hold = 8'd30;
    srst = 1'b1;
    void'($urandom(32'h253e));
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    foreach (idxs[i]) begin
      bus(1'b0, idxs[i], 8'h00);
      chk("reset value", q, 32'h0);
    end
    bus(1'b1, 8'h00, 8'hff);
    bus(1'b0, 8'h00, 8'h00);
    chk("unmapped", q, 32'h0);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 7; i++) begin
        d = 8'($urandom);
        bus(1'b1, idxs[i], d);
        bus(1'b0, idxs[i], 8'h00);
        chk("readback", q, {24'h0, d & rmask(idxs[i])});
      end
    end
    for (int s = 0; s < 15; s++) begin
      lv = 2'($urandom_range(3, 0));
      cfg(s, lv, 1'b1, 1'b1);
      req <= 15'h1 << s;
      repeat (3) @(posedge mclk);
      chk("offer", 32'(offer), 32'({1'b1, 4'(s), lv}));
      cfg(s, lv, 1'b0, 1'b1);
      repeat (2) @(posedge mclk);
      chk("disabled", 32'(offer.valid), 32'h0);
      cfg(s, lv, 1'b1, 1'b0);
      repeat (2) @(posedge mclk);
      chk("global off", 32'(offer.valid), 32'h0);
      req <= 15'h0;
    end
    bus(1'b1, 8'hb7, 8'h00);
    bus(1'b1, 8'hb8, 8'h03);
    bus(1'b1, 8'hf9, 8'h40);
    bus(1'b1, 8'hf8, 8'h40);
    bus(1'b1, 8'he8, 8'h40);
    bus(1'b1, 8'ha8, 8'h83);
    bus(1'b1, 8'hc1, 8'h00);
    auto_en <= 1'b1;
    req[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    req[13] <= 1'b1;
    req[1] <= 1'b1;
    n = 0;
    while ((taken.size() < 3 || rets < 3) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk("first take", 32'(taken[0]), 32'h00);
    chk("preempting take", 32'(taken[1]), 32'hd0);
    chk("waiting take", 32'(taken[2]), 32'h12);
    chk("irq masked", 32'(irq), 32'h0);
    bus(1'b1, 8'hc1, 8'h03);
    @(posedge mclk);
    chk("irq raised", 32'(irq), 32'h1);
    bus(1'b0, 8'hc0, 8'h00);
    chk("status", q, 32'h03);
    @(posedge mclk);
    chk("irq cleared", 32'(irq), 32'h0);
    bus(1'b1, 8'hc1, 8'h04);
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("irq underflow", 32'(irq), 32'h1);
    bus(1'b0, 8'hc0, 8'h00);
    chk("underflow status", q, 32'h04);
    bus(1'b0, 8'hc2, 8'h00);
    chk("service idle", q, 32'h0);
    results();
  end
endmodule
